// *** rtl/nvl_pkg.sv ***
// What this block does
// - Signature reads alternate: odd reads give zero, even reads give ID.
// - Access control register has no effect while strap selects flash.
// - Control bit 6 picks direction: 1 write, 0 read.
// - Writing 1 to bit 7 starts; hardware clears it on finish or abort.
// - Address/data register takes word address first, then data word.
// - Strap is sampled at hardware reset: high flash, low EEPROM.
// - Auto-load finishes within 10 ms after reset release.
// - Interrupt line held low as busy while auto-load runs.
// - Only hardware reset starts auto-load; soft reset never does.
// - Flash mode loads config from flash and maps ID reads there.
// - EEPROM mode loads config, copies ID and card info to upper SRAM.
// - About 34 us per EEPROM word; whole load bounded by 10 ms.
// - Intervening access aborts the sequence and clears go.
// - One word per sequence; word addresses 00 to ff accepted.
// - Address/data register holds its last data until rewritten.
// - Lower 16K of SRAM is ring buffer, rest holds loaded info.
// - Card info starts at 4010; exactly header word count loaded.
// - Card info byte n is read at attribute address 2n.
// - Host writes to SRAM at or above 4000 are ignored.
// - Flash select for attribute 0-3fff and common 4000-1ffff.
package nvl_pkg;
    // -------------------------------------------------------------
    // Register offsets and fields
    // -------------------------------------------------------------
    localparam logic [3:0]  OFS_CTRL     = 4'h2;
    localparam logic [3:0]  OFS_ADDR_DAT = 4'h4;
    localparam logic [11:0] OFS_SIG      = 12'hff4;
    localparam int          BIT_GO       = 7;
    localparam int          BIT_DIR      = 6;
    // -------------------------------------------------------------
    // SRAM and flash map
    // -------------------------------------------------------------
    localparam logic [14:0] SRAM_PROTECT = 15'h4000;
    localparam logic [14:0] ID_BASE      = 15'h4000;
    localparam logic [14:0] CIS_BASE     = 15'h4010;
    localparam logic [16:0] ATTR_HI      = 17'h03fff;
    localparam logic [16:0] COM_LO       = 17'h04000;
    localparam logic [16:0] COM_HI       = 17'h1ffff;
    localparam logic [16:0] FLASH_ID     = 17'h00000;
    // -------------------------------------------------------------
    // EEPROM word layout: header, config, ID area, card info
    // -------------------------------------------------------------
    localparam logic [7:0]  W_CFG0       = 8'h01;
    localparam logic [7:0]  W_CFG1       = 8'h02;
    localparam logic [7:0]  W_ID0        = 8'h03;
    localparam logic [7:0]  W_ID_LAST    = 8'h0a;
    // -------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------
    localparam int CLK_MHZ       = 250;
    localparam int LOAD_LIMIT_MS = 10;
    localparam int WORD_TIME_US  = 34;
    localparam int LOAD_LIMIT_CYC = LOAD_LIMIT_MS * 1000 * CLK_MHZ;
    localparam int WORD_CYC      = WORD_TIME_US * CLK_MHZ;
    // -------------------------------------------------------------
    // Carriers
    // -------------------------------------------------------------
    typedef struct packed {
        logic        we;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } nvl_nvm_cmd_t;
    typedef struct packed {
        logic        we;
        logic [14:0] addr;
        logic [7:0]  data;
    } nvl_sram_wr_t;
endpackage

// *** rtl/nvl_loader.sv ***
`timescale 1ns/1ns
module nvl_loader #(
    parameter int         LOAD_LIMIT = nvl_pkg::LOAD_LIMIT_CYC,
    parameter logic [7:0] SIG_ID     = 8'ha5  // Arbitrary value.
) (
    // Clock and hardware reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // Strap
    input  wire logic                  nvm_select_strap,
    // Page 3 register port
    input  wire logic                  io_rd,
    input  wire logic                  io_wr,
    input  wire logic [3:0]            io_addr,
    input  wire logic [15:0]           io_wdata,
    output logic      [15:0]           io_rdata,
    // Signature read
    input  wire logic                  sig_rd,
    output logic      [7:0]            sig_data,
    // Nonvolatile word engine
    output logic                       nvm_req,
    output nvl_pkg::nvl_nvm_cmd_t      nvm_cmd,
    input  wire logic                  nvm_done,
    input  wire logic [15:0]           nvm_rdata,
    // Configuration register load
    output logic                       cfg_we,
    output logic                       cfg_idx,
    output logic      [15:0]           cfg_data,
    // SRAM side
    output nvl_pkg::nvl_sram_wr_t      sram_wr,
    input  wire logic                  host_mem_wr,
    input  wire logic [14:0]           host_mem_addr,
    output logic                       sram_host_we,
    input  wire logic                  attr_rd,
    input  wire logic [8:0]            attr_addr,
    output logic      [14:0]           cis_sram_addr,
    input  wire logic                  id_rd,
    input  wire logic [2:0]            id_idx,
    output logic      [16:0]           id_src_addr,
    output logic                       id_src_flash,
    // Flash decode
    input  wire logic                  mem_req,
    input  wire logic                  mem_attr,
    input  wire logic [16:0]           mem_addr,
    output logic                       flash_cs_n,
    // Status
    output logic                       ireq_n,
    output logic                       load_done
);
    typedef enum logic [2:0] {
        ST_STRAP, ST_FETCH, ST_WAIT, ST_HI, ST_HOST
    } nvl_ld_t;
    typedef enum logic [1:0] {HS_IDLE, HS_ADDR, HS_DATA, HS_RUN} nvl_hs_t;

    nvl_ld_t     ld_st;
    nvl_hs_t     hs_st;
    logic        strap_q;
    logic        go;
    logic        dir;
    logic [7:0]  ee_addr;
    logic [15:0] adr;
    logic [7:0]  widx;
    logic [7:0]  wlast;
    logic [15:0] wbuf;
    logic [31:0] ld_timer;
    logic        sig_tog;

    // -------------------------------------------------------------
    // Decode
    // -------------------------------------------------------------
    // The ID area and the card info area are contiguous, so one
    // formula places every loaded byte pair.
    wire wr_ctrl  = io_wr && io_addr == nvl_pkg::OFS_CTRL;
    wire wr_adr   = io_wr && io_addr == nvl_pkg::OFS_ADDR_DAT;
    wire rd_ctrl  = io_rd && io_addr == nvl_pkg::OFS_CTRL;
    wire any_io   = io_rd || io_wr;
    wire start_ok = wr_ctrl && io_wdata[nvl_pkg::BIT_GO] && !strap_q
                    && ld_st == ST_HOST && hs_st == HS_IDLE;
    wire abort_a  = hs_st == HS_ADDR && any_io && !wr_adr;
    wire abort_d  = hs_st == HS_DATA && any_io && !wr_adr;
    wire run_done = hs_st == HS_RUN && nvm_done;
    wire timeout  = ld_timer >= 32'(LOAD_LIMIT - 1);
    wire is_cfg   = widx == nvl_pkg::W_CFG0 || widx == nvl_pkg::W_CFG1;
    wire [14:0] byte_addr = nvl_pkg::ID_BASE
        + {6'h00, widx - nvl_pkg::W_ID0, 1'b0};
    wire ld_busy  = ld_st != ST_HOST;
    wire flash_hit = strap_q && mem_req
        && ((mem_attr && mem_addr <= nvl_pkg::ATTR_HI)
        || (!mem_attr && mem_addr >= nvl_pkg::COM_LO
            && mem_addr <= nvl_pkg::COM_HI));

    // -------------------------------------------------------------
    // Auto-load sequencer
    // -------------------------------------------------------------
    // Only rst reaches this machine, so a soft reset cannot rerun it.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ld_st <= ST_STRAP;
            strap_q <= 1'b0;
            widx <= 8'h00;
            wlast <= 8'h00;
            wbuf <= 16'h0000;
        end else if (timeout) begin
            // Checked in every state, so a load cut off between words
            // still stops at the limit instead of one word past it.
            ld_st <= ST_HOST;
        end else begin
            case (ld_st)
                ST_STRAP: begin
                    strap_q <= nvm_select_strap;
                    // Flash holds config only; EEPROM starts at header.
                    widx <= nvm_select_strap ? nvl_pkg::W_CFG0 : 8'h00;
                    wlast <= nvl_pkg::W_CFG1;
                    ld_st <= ST_FETCH;
                end
                ST_FETCH: ld_st <= ST_WAIT;
                ST_WAIT: begin
                    if (timeout) begin
                        ld_st <= ST_HOST;
                    end else if (nvm_done) begin
                        wbuf <= nvm_rdata;
                        if (widx == 8'h00) begin
                            // Card info length is the header count.
                            wlast <= nvl_pkg::W_ID_LAST
                                + nvm_rdata[7:0];
                        end
                        if (widx >= nvl_pkg::W_ID0) begin
                            ld_st <= ST_HI;
                        end else if (widx == wlast && widx != 8'h00) begin
                            ld_st <= ST_HOST;
                        end else begin
                            widx <= widx + 8'h01;
                            ld_st <= ST_FETCH;
                        end
                    end
                end
                ST_HI: begin
                    widx <= widx + 8'h01;
                    ld_st <= (widx == wlast) ? ST_HOST : ST_FETCH;
                end
                ST_HOST: ld_st <= ST_HOST;
                default: ld_st <= ST_HOST;
            endcase
        end
    end

    // Timer bounding the whole load from reset release.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ld_timer <= 32'h0000_0000;
        end else if (ld_busy) begin
            ld_timer <= ld_timer + 32'h0000_0001;
        end
    end

    // -------------------------------------------------------------
    // Configuration and SRAM writes from the loader
    // -------------------------------------------------------------
    // Low byte lands at the even address, high byte one later.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg_we <= 1'b0;
            cfg_idx <= 1'b0;
            cfg_data <= 16'h0000;
            sram_wr <= '0;
        end else begin
            cfg_we <= ld_st == ST_WAIT && nvm_done && is_cfg && !timeout;
            cfg_idx <= widx == nvl_pkg::W_CFG1;
            cfg_data <= nvm_rdata;
            sram_wr.we <= (ld_st == ST_WAIT && nvm_done && !timeout
                && widx >= nvl_pkg::W_ID0) || ld_st == ST_HI;
            sram_wr.addr <= byte_addr + {14'h0000, ld_st == ST_HI};
            sram_wr.data <= (ld_st == ST_HI) ? wbuf[15:8]
                                             : nvm_rdata[7:0];
        end
    end

    // -------------------------------------------------------------
    // Host EEPROM sequence
    // -------------------------------------------------------------
    // A stray access between the steps drops the whole sequence.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hs_st <= HS_IDLE;
            go <= 1'b0;
            dir <= 1'b0;
            ee_addr <= 8'h00;
        end else begin
            case (hs_st)
                HS_IDLE: if (start_ok) begin
                    go <= 1'b1;
                    dir <= io_wdata[nvl_pkg::BIT_DIR];
                    hs_st <= HS_ADDR;
                end
                HS_ADDR: if (abort_a) begin
                    go <= 1'b0;
                    hs_st <= HS_IDLE;
                end else if (wr_adr) begin
                    ee_addr <= io_wdata[7:0];
                    hs_st <= dir ? HS_DATA : HS_RUN;
                end
                HS_DATA: if (abort_d) begin
                    go <= 1'b0;
                    hs_st <= HS_IDLE;
                end else if (wr_adr) begin
                    hs_st <= HS_RUN;
                end
                HS_RUN: if (nvm_done) begin
                    go <= 1'b0;
                    hs_st <= HS_IDLE;
                end
                default: hs_st <= HS_IDLE;
            endcase
        end
    end

    // Address/data register keeps its value until written or loaded by an EEPROM read.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            adr <= 16'h0000;
        end else if (run_done && !dir) begin
            adr <= nvm_rdata;
        end else if (wr_adr) begin
            adr <= io_wdata;
        end
    end

    // -------------------------------------------------------------
    // Word engine request, shared by loader and host
    // -------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            nvm_req <= 1'b0;
            nvm_cmd <= '0;
        end else if (nvm_done) begin
            nvm_req <= 1'b0;
        end else if (ld_st == ST_FETCH) begin
            nvm_req <= 1'b1;
            nvm_cmd <= '{we: 1'b0, addr: widx, wdata: 16'h0000};
        end else if (hs_st != HS_RUN && (wr_adr && ((hs_st == HS_ADDR
                     && !dir) || hs_st == HS_DATA))) begin
            nvm_req <= 1'b1;
            nvm_cmd.we <= dir;
            nvm_cmd.addr <= (hs_st == HS_ADDR) ? io_wdata[7:0] : ee_addr;
            nvm_cmd.wdata <= io_wdata;
        end
    end

    // -------------------------------------------------------------
    // Register reads, signature and host mapping
    // -------------------------------------------------------------
    // Reserved control bits read as zero whatever software wrote.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            io_rdata <= 16'h0000;
            sig_data <= 8'h00;
            sig_tog <= 1'b0;
        end else begin
            if (io_rd) begin
                io_rdata <= rd_ctrl ? {8'h00, go, dir, 6'h00} : adr;
            end
            if (sig_rd) begin
                sig_data <= sig_tog ? SIG_ID : 8'h00;
                sig_tog <= ~sig_tog;
            end
        end
    end

    // Host-facing maps; all registered so outputs come from flops.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sram_host_we <= 1'b0;
            cis_sram_addr <= nvl_pkg::CIS_BASE;
            id_src_addr <= 17'h00000;
            id_src_flash <= 1'b0;
            flash_cs_n <= 1'b1;
            ireq_n <= 1'b0;
            load_done <= 1'b0;
        end else begin
            sram_host_we <= host_mem_wr
                && host_mem_addr < nvl_pkg::SRAM_PROTECT;
            if (attr_rd) begin
                cis_sram_addr <= nvl_pkg::CIS_BASE
                    + {7'h00, attr_addr[8:1]};
            end
            if (id_rd) begin
                id_src_flash <= strap_q;
                id_src_addr <= strap_q
                    ? nvl_pkg::FLASH_ID + {14'h0000, id_idx}
                    : {2'b00, nvl_pkg::ID_BASE} + {14'h0000, id_idx};
            end
            flash_cs_n <= !flash_hit;
            ireq_n <= !ld_busy;
            load_done <= !ld_busy;
        end
    end

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    sequence seq_stray_after_start;
        hs_st == HS_ADDR && any_io && !wr_adr;
    endsequence

    chk_sig_odd_zero: assert property (@(posedge clk_sys) disable iff (rst)
        sig_rd && !sig_tog |=> sig_data == 8'h00 && sig_tog)
        else $error("Odd signature read not zero.");
    chk_sig_even_id: assert property (@(posedge clk_sys) disable iff (rst)
        sig_rd && sig_tog |=> sig_data == SIG_ID && !sig_tog)
        else $error("Even signature read not the ID.");
    chk_ctrl_inhibit: assert property (@(posedge clk_sys) disable iff (rst)
        strap_q |-> !go && hs_st == HS_IDLE)
        else $error("Control register acted in flash mode.");
    chk_dir_latch: assert property (@(posedge clk_sys) disable iff (rst)
        start_ok |=> go && dir == $past(io_wdata[nvl_pkg::BIT_DIR]))
        else $error("Direction not taken from bit 6.");
    chk_abort_clears: assert property (@(posedge clk_sys) disable iff (rst)
        seq_stray_after_start |=> !go && hs_st == HS_IDLE)
        else $error("Stray access did not abort.");
    chk_go_ends: assert property (@(posedge clk_sys) disable iff (rst)
        run_done |=> !go && hs_st == HS_IDLE)
        else $error("Go bit not cleared at finish.");
    chk_busy_line: assert property (@(posedge clk_sys) disable iff (rst)
        ld_busy |=> !ireq_n)
        else $error("Busy not shown during load.");
    chk_load_bound: assert property (@(posedge clk_sys) disable iff (rst)
        ld_timer <= 32'(LOAD_LIMIT))
        else $error("Auto-load ran past its limit.");
    chk_sram_protect: assert property (@(posedge clk_sys) disable iff (rst)
        host_mem_wr && host_mem_addr >= nvl_pkg::SRAM_PROTECT
        |=> !sram_host_we)
        else $error("Protected SRAM write let through.");
    chk_cis_map: assert property (@(posedge clk_sys) disable iff (rst)
        attr_rd |=> cis_sram_addr
            == nvl_pkg::CIS_BASE + {7'h00, $past(attr_addr[8:1])})
        else $error("Card info address wrong.");
    chk_flash_sel: assert property (@(posedge clk_sys) disable iff (rst)
        flash_hit |=> !flash_cs_n)
        else $error("Flash select missing.");
    chk_adr_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !wr_adr && !run_done |=> $stable(adr))
        else $error("Address/data register changed.");
endmodule

// *** testbench/nvl_word_engine.sv ***
`timescale 1ns/1ns
module nvl_word_engine #(
    parameter int DLY = 12
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // Word requests from the loader
    input  wire logic                  nvm_req,
    input  wire nvl_pkg::nvl_nvm_cmd_t nvm_cmd,
    output logic                       nvm_done,
    output logic      [15:0]           nvm_rdata
);
    logic [15:0] mem [0:255];
    int          d;
    // Serve one word at a time, alternating quick and slow answers.
    // Between answers the data lines toggle, so a stale word is caught.
    initial begin
        nvm_done = 1'b0;
        nvm_rdata = 16'h0000;
        d = 1;
        forever begin
            @(posedge clk_sys);
            nvm_rdata <= ~nvm_rdata;
            if (nvm_req && !rst) begin
                d = (d == 1) ? DLY : 1;
                repeat (d) @(posedge clk_sys);
                nvm_rdata <= mem[nvm_cmd.addr];
                if (nvm_cmd.we) mem[nvm_cmd.addr] <= nvm_cmd.wdata;
                nvm_done <= 1'b1;
                @(posedge clk_sys);
                nvm_done <= 1'b0;
                @(posedge clk_sys);
            end
        end
    end
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    localparam int         LIM = 2000;
    localparam logic [7:0] SIG = 8'h3c;  // Arbitrary value.
    logic clk_sys, rst, strap, io_rd, io_wr, sig_rd, nvm_done, cfg_we;
    logic cfg_idx, host_mem_wr, sram_host_we, attr_rd, id_rd, id_src_flash;
    logic mem_req, mem_attr, flash_cs_n, ireq_n, load_done, nvm_req, req_q;
    logic [3:0]  io_addr;
    logic [15:0] io_wdata, io_rdata, nvm_rdata, cfg_data, d;
    logic [7:0]  sig_data, a;
    logic [14:0] host_mem_addr, cis_sram_addr;
    logic [8:0]  attr_addr;
    logic [2:0]  id_idx;
    logic [16:0] id_src_addr, mem_addr;
    nvl_pkg::nvl_nvm_cmd_t nvm_cmd;
    nvl_pkg::nvl_sram_wr_t sram_wr;
    int n_errors, check_count, n_sram, n_cfg, n_req, r, seed;

    nvl_loader #(.LOAD_LIMIT(LIM), .SIG_ID(SIG)) dut (
        .clk_sys(clk_sys), .rst(rst), .nvm_select_strap(strap),
        .io_rd(io_rd), .io_wr(io_wr), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .sig_rd(sig_rd),
        .sig_data(sig_data), .nvm_req(nvm_req), .nvm_cmd(nvm_cmd),
        .nvm_done(nvm_done), .nvm_rdata(nvm_rdata), .cfg_we(cfg_we),
        .cfg_idx(cfg_idx), .cfg_data(cfg_data), .sram_wr(sram_wr),
        .host_mem_wr(host_mem_wr), .host_mem_addr(host_mem_addr),
        .sram_host_we(sram_host_we), .attr_rd(attr_rd),
        .attr_addr(attr_addr), .cis_sram_addr(cis_sram_addr),
        .id_rd(id_rd), .id_idx(id_idx), .id_src_addr(id_src_addr),
        .id_src_flash(id_src_flash), .mem_req(mem_req),
        .mem_attr(mem_attr), .mem_addr(mem_addr),
        .flash_cs_n(flash_cs_n), .ireq_n(ireq_n), .load_done(load_done));
    nvl_word_engine eng (
        .clk_sys(clk_sys), .rst(rst), .nvm_req(nvm_req),
        .nvm_cmd(nvm_cmd), .nvm_done(nvm_done), .nvm_rdata(nvm_rdata));

    // Free-running 250 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("Counts: %0d checks, %0d mismatches", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Expected loaded byte: ID words fill 4000 up, card words 4010 up.
    function automatic logic [7:0] exp_byte(logic [14:0] ad);
        logic [15:0] w;
        if (ad < 15'h4010) w = eng.mem[3 + (ad - 15'h4000) / 2];
        else w = eng.mem[11 + (ad - 15'h4010) / 2];
        return ad[0] ? w[15:8] : w[7:0];
    endfunction

    // Watch load traffic and count word requests to the engine.
    always @(posedge clk_sys) begin
        if (sram_wr.we) begin
            n_sram++;
            chk("sram byte", exp_byte(sram_wr.addr), sram_wr.data);
        end
        if (cfg_we) begin
            n_cfg++;
            chk("cfg word", eng.mem[cfg_idx + 1], cfg_data);
        end
        if (nvm_req && !req_q) n_req++;
        req_q <= nvm_req;
    end

    // One register access; read data is settled at the closing edge.
    task automatic io(input logic wr, input logic [3:0] ad,
                      input logic [15:0] dt);
        @(negedge clk_sys);
        io_wr = wr;
        io_rd = !wr;
        io_addr = ad;
        io_wdata = dt;
        @(negedge clk_sys);
        io_wr = 1'b0;
        io_rd = 1'b0;
    endtask

    task automatic poll();
        int k;
        k = 0;
        do begin
            io(1'b0, nvl_pkg::OFS_CTRL, 16'h0000);
            k++;
        end while (io_rdata[7] !== 1'b0 && k < 200);
        chk("go clears", 0, io_rdata[7]);
    endtask

    // Hardware reset with a strap level, then wait for the load.
    task automatic hw_reset(input logic s);
        int k;
        strap = s;
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        n_sram = 0;
        n_cfg = 0;
        @(negedge clk_sys);
        chk("busy", 0, ireq_n);
        for (k = 0; k < LIM + 100 && load_done !== 1'b1; k++) @(negedge clk_sys);
        chk("load done", 1, load_done);
        chk("ready", 1, ireq_n);
        chk("cfg count", 2, n_cfg);
        chk("sram count", s ? 0 : 16 + 10, n_sram);
    endtask

    // Host-side decodes with random stimulus in the given mode.
    task automatic decodes(input logic s);
        logic [17:0] eid;
        logic        ecs;
        for (int i = 0; i < 12; i++) begin
            @(negedge clk_sys);
            host_mem_wr = 1'b1;
            host_mem_addr = 15'($random(seed));
            attr_rd = 1'b1;
            attr_addr = 9'($random(seed));
            id_rd = 1'b1;
            id_idx = 3'(i);
            mem_req = 1'($random(seed));
            mem_attr = i[0];
            mem_addr = {i[1] ? 3'($random(seed)) : 3'h0, 14'($random(seed))};
            @(negedge clk_sys);
            host_mem_wr = 1'b0;
            attr_rd = 1'b0;
            id_rd = 1'b0;
            chk("host write", host_mem_addr < 15'h4000, sram_host_we);
            chk("cis addr", 15'h4010 + attr_addr[8:1], cis_sram_addr);
            // The index port is three bits, so the entries repeat by 8.
            eid = s ? {1'b1, nvl_pkg::FLASH_ID + 17'(id_idx)}
                    : {1'b0, 17'(nvl_pkg::ID_BASE) + 17'(id_idx)};
            chk("id source", eid, {id_src_flash, id_src_addr});
            ecs = !(s && mem_req && (mem_attr
                ? mem_addr <= nvl_pkg::ATTR_HI
                : mem_addr >= nvl_pkg::COM_LO));
            chk("flash cs", ecs, flash_cs_n);
        end
    endtask

    // Main sequence.
    initial begin
        {rst, strap, io_rd, io_wr, sig_rd, host_mem_wr, attr_rd, id_rd} = 8'h80;
        {mem_req, mem_attr, io_addr, io_wdata, host_mem_addr} = '0;
        {attr_addr, id_idx, mem_addr, req_q} = '0;
        {n_errors, check_count, n_req} = '0;
        seed = 32'h6ec41cc7;
        for (int i = 0; i < 256; i++) eng.mem[i] = 16'($random(seed));
        eng.mem[0] = 16'h0005;
        hw_reset(1'b0);
        $display("Test eeprom load done");
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_sys);
            sig_rd = 1'b1;
            @(negedge clk_sys);
            sig_rd = 1'b0;
            chk("signature", i[0] ? SIG : 8'h00, sig_data);
        end
        for (int i = 0; i < 3; i++) begin
            a = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
            d = 16'($random(seed));
            io(1'b1, nvl_pkg::OFS_CTRL, 16'h00c0);
            io(1'b1, nvl_pkg::OFS_ADDR_DAT, {8'h00, a});
            io(1'b1, nvl_pkg::OFS_ADDR_DAT, d);
            poll();
            chk("eeprom word", d, eng.mem[a]);
            io(1'b1, nvl_pkg::OFS_CTRL, 16'h0080);
            io(1'b1, nvl_pkg::OFS_ADDR_DAT, {8'h00, a});
            poll();
            io(1'b0, nvl_pkg::OFS_ADDR_DAT, 16'h0000);
            chk("read word", d, io_rdata);
            io(1'b0, nvl_pkg::OFS_CTRL, 16'h0000);
            io(1'b0, nvl_pkg::OFS_ADDR_DAT, 16'h0000);
            chk("held word", d, io_rdata);
        end
        $display("Test eeprom sequences done");
        r = n_req;
        io(1'b1, nvl_pkg::OFS_CTRL, 16'h00c0);
        io(1'b0, nvl_pkg::OFS_CTRL, 16'h0000);
        io(1'b0, nvl_pkg::OFS_CTRL, 16'h0000);
        chk("abort go", 0, io_rdata[7]);
        // A stray read in the data step must drop the sequence too.
        io(1'b1, nvl_pkg::OFS_CTRL, 16'h00c0);
        io(1'b1, nvl_pkg::OFS_ADDR_DAT, 16'h0010);
        io(1'b0, nvl_pkg::OFS_CTRL, 16'h0000);
        io(1'b0, nvl_pkg::OFS_CTRL, 16'h0000);
        chk("abort data go", 0, io_rdata[7]);
        io(1'b1, nvl_pkg::OFS_ADDR_DAT, 16'h1234);
        repeat (20) @(negedge clk_sys);
        chk("abort req", r, n_req);
        decodes(1'b0);
        $display("Test eeprom decodes done");
        hw_reset(1'b1);
        r = n_req;
        io(1'b1, nvl_pkg::OFS_CTRL, 16'h00c0);
        io(1'b1, nvl_pkg::OFS_ADDR_DAT, 16'h0010);
        io(1'b1, nvl_pkg::OFS_ADDR_DAT, 16'h5678);
        repeat (20) @(negedge clk_sys);
        chk("flash req", r, n_req);
        io(1'b0, nvl_pkg::OFS_CTRL, 16'h0000);
        chk("flash go", 0, io_rdata[7]);
        decodes(1'b1);
        $display("Test flash mode done");
        give_verdict();
    end

    // Cut a hang short well past the expected run length.
    initial begin
        repeat (30000) @(posedge clk_sys);
        n_errors++;
        give_verdict();
    end
endmodule
